// ==== shared/llic_regs.svh ====
`ifndef LLIC_REGS_SVH
`define LLIC_REGS_SVH

// register offsets on the control port
`define LLIC_OFS_MASK0 8'h14
`define LLIC_OFS_MASK1 8'h15
`define LLIC_OFS_EDGE 8'h16
`define LLIC_OFS_STATUS0 8'h17
`define LLIC_OFS_PEND0 8'h19
`define LLIC_OFS_PEND1 8'h1a

// reset values
`define LLIC_MASK0_RST 8'hff
`define LLIC_MASK1_RST 8'hff
`define LLIC_EDGE_RST 8'h00
`define LLIC_UNMAPPED_RD 8'h00

// status-driven source bits (mask 0, edge select, line status 0, pending 0)
`define LLIC_EQ_BIT 7
`define LLIC_LBA_BIT 6
`define LLIC_LBD_BIT 5
`define LLIC_PSYNC_BIT 4
`define LLIC_TXLOSS_BIT 3
`define LLIC_DF_BIT 2
`define LLIC_AIS_BIT 1
`define LLIC_LOS_BIT 0

// event-driven source bits (mask 1, pending 1)
`define LLIC_DAC_BIT 7
`define LLIC_JAOV_BIT 6
`define LLIC_JAUD_BIT 5
`define LLIC_PERR_BIT 4
`define LLIC_EXZ_BIT 3
`define LLIC_CV_BIT 2
`define LLIC_TIMER_BIT 1
`define LLIC_CNT_BIT 0

// transmit clock is lost after more than this many master clock cycles
`define LLIC_TXCLK_LOSS_CYCLES 7'd70

`endif

// ==== shared/llic_pkg.sv ====
package llic_pkg;

    typedef logic [7:0] llic_byte_t;
    typedef logic [15:0] llic_src_t;

    typedef enum logic [0:0]
    {
        LLIC_CLK_RUNNING = 1'b0,
        LLIC_CLK_LOST = 1'b1
    } llic_clk_state_e;

endpackage

// ==== design/llic_event_latch.sv ====
`timescale 1ns/1ps

module llic_event_latch
    import llic_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // source and controls
    input wire logic statusIn,
    input wire logic edgeSel,
    input wire logic maskBit,
    input wire logic clearReq,
    // result
    output logic pending
);

    logic statusPrev_q;
    logic pending_q;
    logic pending_d;
    logic eventHit;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            statusPrev_q <= 1'b0;
        else
            statusPrev_q <= statusIn;
    end

    // rising edge always counts, falling edge only with edgeSel high
    assign eventHit = (statusIn & ~statusPrev_q) | (edgeSel & ~statusIn & statusPrev_q);

    // a new event beats a clear in the same cycle so it is never lost
    always_comb
    begin
        pending_d = pending_q;
        if (clearReq)
            pending_d = 1'b0;
        if (eventHit && !maskBit)
            pending_d = 1'b1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pending_q <= 1'b0;
        else
            pending_q <= pending_d;
    end

    assign pending = pending_q;

endmodule

// ==== design/llic_tx_clock_monitor.sv ====
`timescale 1ns/1ps
`include "llic_regs.svh"

module llic_tx_clock_monitor
    import llic_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // monitored pin
    input wire logic transmitClockIn,
    // loss indication
    output logic txClockLossFlag
);

    logic clkPrev_q;
    logic [6:0] idleCnt_q;
    llic_clk_state_e state_q;
    logic toggled;

    assign toggled = transmitClockIn ^ clkPrev_q;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            clkPrev_q <= 1'b0;
        else
            clkPrev_q <= transmitClockIn;
    end

    // counter saturates so a long stall cannot wrap and clear the flag
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            idleCnt_q <= 7'h00;
        else if (toggled)
            idleCnt_q <= 7'h00;
        else if (idleCnt_q < `LLIC_TXCLK_LOSS_CYCLES)
            idleCnt_q <= idleCnt_q + 7'h01;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            state_q <= LLIC_CLK_RUNNING;
        else
        begin
            case (state_q)
                LLIC_CLK_RUNNING:
                    if (!toggled && idleCnt_q >= `LLIC_TXCLK_LOSS_CYCLES)
                        state_q <= LLIC_CLK_LOST;
                LLIC_CLK_LOST:
                    if (toggled)
                        state_q <= LLIC_CLK_RUNNING;
                default:
                    state_q <= LLIC_CLK_RUNNING;
            endcase
        end
    end

    assign txClockLossFlag = (state_q == LLIC_CLK_LOST);

endmodule

// ==== design/llic_interrupt_control.sv ====
`timescale 1ns/1ps
`include "llic_regs.svh"

// Operation
// RULE1 - mask 0 bit 7 gates equalizer out-of-range; 0 enables, resets 1
// RULE2 - mask 0 bit 6 gates loopback activate detect; 0 enables, resets 1
// RULE3 - mask 0 bit 5 gates loopback deactivate detect; 0 enables, resets 1
// RULE4 - mask 0 bit 4 gates pattern sync detect; 0 enables, resets masked
// RULE5 - mask 0 bit 3 gates transmit clock loss; 0 enables, resets masked
// RULE6 - mask 0 bit 2 gates driver failure; 0 enables, resets masked
// RULE7 - mask 0 bit 1 gates alarm indication signal; 0 enables, resets masked
// RULE8 - mask 0 bit 0 gates loss of signal; 0 enables, resets masked
// RULE9 - mask 1 bit 7 gates converter overflow; 0 enables, resets masked
// RULE10 - mask 1 bit 6 gates jitter buffer overflow; 0 enables, resets masked
// RULE11 - mask 1 bit 5 gates jitter buffer underflow; 0 enables, resets masked
// RULE12 - mask 1 bit 4 gates pattern error detect; 0 enables, resets masked
// RULE13 - mask 1 bit 3 gates excess zeros; 0 enables, resets masked
// RULE14 - mask 1 bit 2 gates code violation; 0 enables, resets masked
// RULE15 - mask 1 bit 1 gates one-second tick; 0 enables, resets masked
// RULE16 - mask 1 bit 0 gates counter overflow; 0 enables, resets masked
// RULE17 - edge select 0 fires on rise only, 1 on either change; resets 0
// RULE18 - edge select bit 7 belongs to equalizer out-of-range status
// RULE19 - edge select bits 6 and 5 belong to loopback activate and deactivate
// RULE20 - edge select bits 4 and 3 belong to pattern sync and clock loss
// RULE21 - edge select bits 2, 1, 0 belong to driver failure, alarm, signal loss
// RULE22 - clock loss flag sets after more than 70 cycles without a toggle
// RULE23 - unmasked events latch pending; one interrupt output while any remains
// RULE24 - host sets edge selects before unmasking and unmasks only served sources
module llic_interrupt_control
    import llic_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // status-driven sources
    input wire logic equalizerRangeFlag,
    input wire logic loopActivateFlag,
    input wire logic loopDeactivateFlag,
    input wire logic patternSyncFlag,
    input wire logic driverFailureFlag,
    input wire logic alarmSignalFlag,
    input wire logic signalLossFlag,
    input wire logic transmitClockIn,
    // event-driven sources
    input wire logic converterOverflowEvt,
    input wire logic jitterOverflowEvt,
    input wire logic jitterUnderflowEvt,
    input wire logic patternErrorEvt,
    input wire logic excessZerosEvt,
    input wire logic codeViolationEvt,
    input wire logic secondTickEvt,
    input wire logic counterOverflowEvt,
    // interrupt and monitor outputs
    output logic irqOut_n,
    output logic txClockLossFlag
);

    llic_byte_t mask0_q;
    llic_byte_t mask1_q;
    llic_byte_t edgeSel_q;
    llic_byte_t regRdData_q;
    llic_byte_t regRdData_d;
    llic_byte_t lineStatus0;
    llic_byte_t eventVec;
    llic_src_t maskAll;
    llic_src_t edgeAll;
    llic_src_t sourceVec;
    llic_src_t clearVec;
    llic_src_t pending;
    logic irqOut_n_q;
    logic txLoss;

    // named mask fields
    logic equalizerRangeIrqMask;
    logic loopActivateIrqMask;
    logic loopDeactivateIrqMask;
    logic patternSyncIrqMask;
    logic txClockLossIrqMask;
    logic driverFailureIrqMask;
    logic alarmSignalIrqMask;
    logic signalLossIrqMask;
    logic converterOverflowIrqMask;
    logic jitterOverflowIrqMask;
    logic jitterUnderflowIrqMask;
    logic patternErrorIrqMask;
    logic excessZerosIrqMask;
    logic codeViolationIrqMask;
    logic secondTickIrqMask;
    logic counterOverflowIrqMask;

    // named edge select fields
    logic equalizerRangeEdgeSel;
    logic loopActivateEdgeSel;
    logic loopDeactivateEdgeSel;
    logic patternSyncEdgeSel;
    logic txClockLossEdgeSel;
    logic driverFailureEdgeSel;
    logic alarmSignalEdgeSel;
    logic signalLossEdgeSel;

    llic_tx_clock_monitor u_txClockMon
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .transmitClockIn(transmitClockIn),
        .txClockLossFlag(txLoss)
    );

    assign txClockLossFlag = txLoss; // [RULE22]

    // register writes
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            mask0_q <= `LLIC_MASK0_RST;
        else if (regWrEn && regAddr == `LLIC_OFS_MASK0)
            mask0_q <= regWrData;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            mask1_q <= `LLIC_MASK1_RST;
        else if (regWrEn && regAddr == `LLIC_OFS_MASK1)
            mask1_q <= regWrData;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            edgeSel_q <= `LLIC_EDGE_RST; // [RULE17]
        else if (regWrEn && regAddr == `LLIC_OFS_EDGE)
            edgeSel_q <= regWrData;
    end

    assign equalizerRangeIrqMask = mask0_q[`LLIC_EQ_BIT]; // [RULE1]
    assign loopActivateIrqMask = mask0_q[`LLIC_LBA_BIT]; // [RULE2]
    assign loopDeactivateIrqMask = mask0_q[`LLIC_LBD_BIT]; // [RULE3]
    assign patternSyncIrqMask = mask0_q[`LLIC_PSYNC_BIT]; // [RULE4]
    assign txClockLossIrqMask = mask0_q[`LLIC_TXLOSS_BIT]; // [RULE5]
    assign driverFailureIrqMask = mask0_q[`LLIC_DF_BIT]; // [RULE6]
    assign alarmSignalIrqMask = mask0_q[`LLIC_AIS_BIT]; // [RULE7]
    assign signalLossIrqMask = mask0_q[`LLIC_LOS_BIT]; // [RULE8]
    assign converterOverflowIrqMask = mask1_q[`LLIC_DAC_BIT]; // [RULE9]
    assign jitterOverflowIrqMask = mask1_q[`LLIC_JAOV_BIT]; // [RULE10]
    assign jitterUnderflowIrqMask = mask1_q[`LLIC_JAUD_BIT]; // [RULE11]
    assign patternErrorIrqMask = mask1_q[`LLIC_PERR_BIT]; // [RULE12]
    assign excessZerosIrqMask = mask1_q[`LLIC_EXZ_BIT]; // [RULE13]
    assign codeViolationIrqMask = mask1_q[`LLIC_CV_BIT]; // [RULE14]
    assign secondTickIrqMask = mask1_q[`LLIC_TIMER_BIT]; // [RULE15]
    assign counterOverflowIrqMask = mask1_q[`LLIC_CNT_BIT]; // [RULE16]

    assign equalizerRangeEdgeSel = edgeSel_q[`LLIC_EQ_BIT]; // [RULE18]
    assign loopActivateEdgeSel = edgeSel_q[`LLIC_LBA_BIT]; // [RULE19]
    assign loopDeactivateEdgeSel = edgeSel_q[`LLIC_LBD_BIT]; // [RULE19]
    assign patternSyncEdgeSel = edgeSel_q[`LLIC_PSYNC_BIT]; // [RULE20]
    assign txClockLossEdgeSel = edgeSel_q[`LLIC_TXLOSS_BIT]; // [RULE20]
    assign driverFailureEdgeSel = edgeSel_q[`LLIC_DF_BIT]; // [RULE21]
    assign alarmSignalEdgeSel = edgeSel_q[`LLIC_AIS_BIT]; // [RULE21]
    assign signalLossEdgeSel = edgeSel_q[`LLIC_LOS_BIT]; // [RULE21]

    assign lineStatus0 = {equalizerRangeFlag, loopActivateFlag, loopDeactivateFlag,
        patternSyncFlag, txLoss, driverFailureFlag, alarmSignalFlag, signalLossFlag};

    assign eventVec = {converterOverflowEvt, jitterOverflowEvt, jitterUnderflowEvt,
        patternErrorEvt, excessZerosEvt, codeViolationEvt, secondTickEvt,
        counterOverflowEvt};

    assign sourceVec = {eventVec, lineStatus0};

    assign maskAll = {converterOverflowIrqMask, jitterOverflowIrqMask,
        jitterUnderflowIrqMask, patternErrorIrqMask, excessZerosIrqMask,
        codeViolationIrqMask, secondTickIrqMask, counterOverflowIrqMask,
        equalizerRangeIrqMask, loopActivateIrqMask, loopDeactivateIrqMask,
        patternSyncIrqMask, txClockLossIrqMask, driverFailureIrqMask,
        alarmSignalIrqMask, signalLossIrqMask};

    // pulse sources are rise-only; a falling pulse edge is not a second event
    assign edgeAll = {8'h00, equalizerRangeEdgeSel, loopActivateEdgeSel,
        loopDeactivateEdgeSel, patternSyncEdgeSel, txClockLossEdgeSel,
        driverFailureEdgeSel, alarmSignalEdgeSel, signalLossEdgeSel};

    // pending bits clear by writing ones to the pending registers
    assign clearVec[7:0] = (regWrEn && regAddr == `LLIC_OFS_PEND0) ? regWrData : 8'h00;
    assign clearVec[15:8] = (regWrEn && regAddr == `LLIC_OFS_PEND1) ? regWrData : 8'h00;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_src
            llic_event_latch u_latch
            (
                .sys_clk(sys_clk),
                .rst(rst),
                .statusIn(sourceVec[gi]),
                .edgeSel(edgeAll[gi]),
                .maskBit(maskAll[gi]),
                .clearReq(clearVec[gi]),
                .pending(pending[gi])
            ); // [RULE17] [RULE23]
        end
    endgenerate

    // one combined interrupt, low while anything is pending
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            irqOut_n_q <= 1'b1;
        else
            irqOut_n_q <= ~(|pending); // [RULE23]
    end

    assign irqOut_n = irqOut_n_q;

    // read decode; data appears the cycle after regRdEn
    always_comb
    begin
        if (regAddr == `LLIC_OFS_MASK0)
            regRdData_d = mask0_q;
        else if (regAddr == `LLIC_OFS_MASK1)
            regRdData_d = mask1_q;
        else if (regAddr == `LLIC_OFS_EDGE)
            regRdData_d = edgeSel_q;
        else if (regAddr == `LLIC_OFS_STATUS0)
            regRdData_d = lineStatus0;
        else if (regAddr == `LLIC_OFS_PEND0)
            regRdData_d = pending[7:0];
        else if (regAddr == `LLIC_OFS_PEND1)
            regRdData_d = pending[15:8];
        else
            regRdData_d = `LLIC_UNMAPPED_RD;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            regRdData_q <= 8'h00;
        else if (regRdEn)
            regRdData_q <= regRdData_d;
    end

    assign regRdData = regRdData_q;

    // helper state for the checks below
    llic_byte_t chkStatusPrev_q;
    logic chkTxPrev_q;
    logic [7:0] chkIdle_q;
    llic_byte_t chkRise;
    llic_byte_t chkFall;
    llic_byte_t chkFallSel;
    llic_byte_t chkFallIgn;
    llic_byte_t chkRiseClr;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            chkStatusPrev_q <= 8'h00;
            chkTxPrev_q <= 1'b0;
            chkIdle_q <= 8'h00;
        end
        else
        begin
            chkStatusPrev_q <= lineStatus0;
            chkTxPrev_q <= transmitClockIn;
            if (transmitClockIn != chkTxPrev_q)
                chkIdle_q <= 8'h00;
            else if (chkIdle_q != 8'hff)
                chkIdle_q <= chkIdle_q + 8'h01;
        end
    end

    assign chkRise = lineStatus0 & ~chkStatusPrev_q & ~maskAll[7:0];
    assign chkFall = ~lineStatus0 & chkStatusPrev_q & ~maskAll[7:0];
    assign chkFallSel = chkFall & edgeSel_q;
    assign chkFallIgn = chkFall & ~edgeSel_q & ~pending[7:0];
    assign chkRiseClr = chkRise & clearVec[7:0];

    chk_mask_reset: assert property (@(posedge sys_clk) // [RULE1] [RULE9] [RULE17]
        $fell(rst) |-> (mask0_q == 8'hff && mask1_q == 8'hff && edgeSel_q == 8'h00))
        else $error("masks or edge select not at reset value");

    chk_mask_write: assert property (@(posedge sys_clk) disable iff (rst) // [RULE2]
        (regWrEn && regAddr == 8'h14) |=> (mask0_q == $past(regWrData)))
        else $error("mask 0 write not stored");

    chk_mask1_write: assert property (@(posedge sys_clk) disable iff (rst) // [RULE9]
        (regWrEn && regAddr == `LLIC_OFS_MASK1) |=> (mask1_q == $past(regWrData)))
        else $error("mask 1 write not stored");

    chk_edge_write: assert property (@(posedge sys_clk) disable iff (rst) // [RULE17]
        (regWrEn && regAddr == `LLIC_OFS_EDGE) |=> (edgeSel_q == $past(regWrData)))
        else $error("edge select write not stored");

    chk_masked_hold: assert property (@(posedge sys_clk) disable iff (rst) // [RULE3] [RULE16]
        (maskAll != 16'h0000)
        |=> ((pending & ~$past(pending) & $past(maskAll)) == 16'h0000))
        else $error("masked source latched pending");

    chk_rise_latch: assert property (@(posedge sys_clk) disable iff (rst) // [RULE17]
        (chkRise != 8'h00)
        |=> ((pending[7:0] & $past(chkRise)) == $past(chkRise)))
        else $error("unmasked rise not latched");

    chk_fall_latch: assert property (@(posedge sys_clk) disable iff (rst) // [RULE18] [RULE21]
        (chkFallSel != 8'h00)
        |=> ((pending[7:0] & $past(chkFallSel)) == $past(chkFallSel)))
        else $error("both-edge fall not latched");

    chk_fall_ignored: assert property (@(posedge sys_clk) disable iff (rst) // [RULE17] [RULE20]
        (chkFallIgn != 8'h00 && clearVec == 16'h0000)
        |=> ((pending[7:0] & $past(chkFallIgn)) == 8'h00))
        else $error("rise-only source fired on fall");

    chk_txclk_loss: assert property (@(posedge sys_clk) disable iff (rst) // [RULE22]
        (chkIdle_q == 8'd72) |-> txClockLossFlag)
        else $error("clock loss flag missing after long idle");

    chk_txclk_early: assert property (@(posedge sys_clk) disable iff (rst) // [RULE22]
        (chkIdle_q < 8'd69) |-> !txClockLossFlag)
        else $error("clock loss flag raised too early");

    chk_irq_output: assert property (@(posedge sys_clk) disable iff (rst) // [RULE23]
        (pending != 16'h0000) |=> !irqOut_n)
        else $error("interrupt not asserted while pending");

    chk_irq_release: assert property (@(posedge sys_clk) disable iff (rst) // [RULE23]
        (pending == 16'h0000) |=> irqOut_n)
        else $error("interrupt asserted with nothing pending");

    chk_set_wins: assert property (@(posedge sys_clk) disable iff (rst) // [RULE23]
        (chkRiseClr != 8'h00)
        |=> ((pending[7:0] & $past(chkRiseClr)) == $past(chkRiseClr)))
        else $error("event lost against clear");

    chk_pend_clear: assert property (@(posedge sys_clk) disable iff (rst) // [RULE23]
        (regWrEn && regAddr == `LLIC_OFS_PEND0 && chkRise == 8'h00 && chkFallSel == 8'h00)
        |=> ((pending[7:0] & $past(regWrData)) == 8'h00))
        else $error("pending bit not cleared by write");

    chk_read_mask: assert property (@(posedge sys_clk) disable iff (rst) // [RULE9]
        (regRdEn && regAddr == 8'h15) |=> (regRdData == $past(mask1_q)))
        else $error("mask 1 read back wrong");

endmodule

// ==== dv/llic_host_model.sv ====
`timescale 1ns/1ps
`include "llic_regs.svh"

module llic_host_model
    import llic_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // register port
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn,
    input wire logic [7:0] regRdData,
    // interrupt
    input wire logic irqOut_n
);
    initial
    begin
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regWrData = 8'h00;
        regRdEn = 1'b0;
    end

    // strobes rise just after an edge and drop just after the edge that takes them
    task automatic wr(input llic_byte_t a, input llic_byte_t d);
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge sys_clk);
        #1;
        regWrEn = 1'b0;
    endtask

    // read data lands at the taking edge and is sampled just after it
    task automatic rd(input llic_byte_t a, output llic_byte_t d);
        @(posedge sys_clk);
        #1;
        regAddr = a;
        regRdEn = 1'b1;
        @(posedge sys_clk);
        #1;
        regRdEn = 1'b0;
        d = regRdData;
    endtask

    // edge selects go in before unmasking, so no stale change fires
    task automatic setup(input llic_byte_t e, input llic_byte_t m);
        wr(`LLIC_OFS_EDGE, e);
        wr(`LLIC_OFS_MASK0, m);
    endtask

    // service: read what is pending and write it back to clear only those
    task automatic ack(input llic_byte_t a, output llic_byte_t p);
        rd(a, p);
        wr(a, p);
    endtask
endmodule

// ==== dv/llic_interrupt_control_tb.sv ====
`timescale 1ns/1ps
`include "llic_regs.svh"

`define CHK(what, exp, got) \
    begin \
        cmp_count++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("[ERR] %s expected %h seen %h", what, exp, got); \
        end \
    end

module llic_interrupt_control_tb
    import llic_pkg::*;
    ;
    logic sys_clk;
    logic rst;
    logic [7:0] regAddr;
    logic regWrEn;
    logic [7:0] regWrData;
    logic regRdEn;
    logic [7:0] regRdData;
    logic [7:0] stat;
    logic [7:0] evt;
    logic txClk;
    logic txTog;
    logic irqOut_n;
    logic txClockLossFlag;
    llic_byte_t p;
    int mismatches;
    int cmp_count;

    llic_interrupt_control llic_interrupt_control_inst (
        .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .equalizerRangeFlag(stat[7]), .loopActivateFlag(stat[6]),
        .loopDeactivateFlag(stat[5]), .patternSyncFlag(stat[4]),
        .driverFailureFlag(stat[2]), .alarmSignalFlag(stat[1]), .signalLossFlag(stat[0]),
        .transmitClockIn(txClk), .converterOverflowEvt(evt[7]), .jitterOverflowEvt(evt[6]),
        .jitterUnderflowEvt(evt[5]), .patternErrorEvt(evt[4]), .excessZerosEvt(evt[3]),
        .codeViolationEvt(evt[2]), .secondTickEvt(evt[1]), .counterOverflowEvt(evt[0]),
        .irqOut_n(irqOut_n), .txClockLossFlag(txClockLossFlag));

    llic_host_model llic_host_model_inst (
        .sys_clk(sys_clk), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .irqOut_n(irqOut_n));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // transmit clock toggles every cycle while enabled
    // enable is sampled at the edge, so a change made after the edge acts one cycle later
    always @(posedge sys_clk)
    begin
        if (txTog)
            txClk <= #1 ~txClk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic t_reset;
        `CHK("irq idle", 1'b1, irqOut_n);
        llic_host_model_inst.rd(`LLIC_OFS_MASK0, p);
        `CHK("mask0 rst", 8'hff, p);
        llic_host_model_inst.rd(`LLIC_OFS_MASK1, p);
        `CHK("mask1 rst", 8'hff, p);
        llic_host_model_inst.rd(`LLIC_OFS_EDGE, p);
        `CHK("edge rst", 8'h00, p);
        llic_host_model_inst.rd(8'h20, p);
        `CHK("unmapped", 8'h00, p);
    endtask

    // one source unmasked at a time, clock loss bit 3 skipped; all other status bits fire too and must be dropped
    task automatic t_mask0;
        for (int i = 0; i < 8; i++)
        begin
            if (i == 3)
                continue;
            llic_host_model_inst.setup(8'h00, ~(8'h01 << i));
            stat = 8'hf7;
            cyc(1);
            stat = 8'h00;
            cyc(3);
            `CHK("irq low", 1'b0, irqOut_n);
            llic_host_model_inst.ack(`LLIC_OFS_PEND0, p);
            `CHK("pend0", 8'h01 << i, p);
            cyc(2);
            `CHK("irq high", 1'b1, irqOut_n);
        end
    endtask

    task automatic t_mask1;
        for (int i = 0; i < 8; i++)
        begin
            llic_host_model_inst.wr(`LLIC_OFS_MASK1, ~(8'h01 << i));
            evt = 8'hff;
            cyc(1);
            evt = 8'h00;
            cyc(3);
            `CHK("irq low", 1'b0, irqOut_n);
            llic_host_model_inst.ack(`LLIC_OFS_PEND1, p);
            `CHK("pend1", 8'h01 << i, p);
        end
        llic_host_model_inst.wr(`LLIC_OFS_MASK1, 8'hff);
    endtask

    // only the selected source may fire on a falling status bit
    task automatic t_edge;
        for (int i = 0; i < 8; i++)
        begin
            if (i == 3)
                continue;
            llic_host_model_inst.wr(`LLIC_OFS_MASK0, 8'hff);
            stat = 8'hf7;
            cyc(2);
            llic_host_model_inst.rd(`LLIC_OFS_STATUS0, p);
            `CHK("status0", 8'hf7, p);
            llic_host_model_inst.setup(8'h01 << i, 8'h00);
            stat = 8'h00;
            cyc(3);
            llic_host_model_inst.ack(`LLIC_OFS_PEND0, p);
            `CHK("fall pend0", 8'h01 << i, p);
        end
    endtask

    task automatic t_clock;
        int n;
        llic_host_model_inst.wr(`LLIC_OFS_MASK0, 8'hff);
        llic_host_model_inst.setup(8'h08, 8'hf7);
        txTog = 1'b0;
        for (n = 0; n < 100 && txClockLossFlag !== 1'b1; n++)
            cyc(1);
        `CHK("loss delay", 1'b1, n >= 71 && n <= 72);
        cyc(3);
        llic_host_model_inst.rd(`LLIC_OFS_STATUS0, p);
        `CHK("status0 loss", 8'h08, p);
        llic_host_model_inst.ack(`LLIC_OFS_PEND0, p);
        `CHK("loss pend", 8'h08, p);
        txTog = 1'b1;
        cyc(3);
        `CHK("loss clear", 1'b0, txClockLossFlag);
        llic_host_model_inst.ack(`LLIC_OFS_PEND0, p);
        `CHK("restore pend", 8'h08, p);
    endtask

    // a rise taken at the same edge as a clear of its bit must stay pending
    task automatic t_race;
        llic_host_model_inst.setup(8'h00, 8'hfe);
        fork
            llic_host_model_inst.wr(`LLIC_OFS_PEND0, 8'h01);
            begin
                @(posedge sys_clk);
                #1;
                stat = 8'h01;
            end
        join
        cyc(2);
        `CHK("irq on race", 1'b0, irqOut_n);
        llic_host_model_inst.ack(`LLIC_OFS_PEND0, p);
        `CHK("set wins", 8'h01, p);
        stat = 8'h00;
    endtask

    initial
    begin
        #200us;
        mismatches++;
        test_done();
    end

    initial
    begin
        mismatches = 0;
        cmp_count = 0;
        rst = 1'b1;
        stat = 8'h00;
        evt = 8'h00;
        txClk = 1'b0;
        txTog = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        cyc(1);
        t_reset();
        t_mask0();
        t_mask1();
        t_edge();
        t_clock();
        t_race();
        test_done();
    end
endmodule
